// ===== ccs_terminal.sv
// ccs_terminal: channel end of the control/status byte protocol.
// assumes control bytes come from logic on the same clock; analog values arrive as inputs.
// the feature value is taken over on a single reset edge; a longer reset clears it first.
`default_nettype none
module ccs_terminal #(
  parameter int SLOW_CYCLES = ccs_pkg::SLOW_CYC,
  parameter int FAST_CYCLES = ccs_pkg::FAST_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  ccs_link_if.terminal link,
  input wire logic [15:0] i_sample,
  input wire logic i_error,
  input wire logic i_overrange,
  input wire logic i_underrange,
  input wire logic [15:0] i_limit1,
  input wire logic [15:0] i_limit2,
  input wire logic i_limit1_en,
  input wire logic i_limit2_en,
  output logic o_comp_en,
  output logic o_cal_step,
  output logic o_cal_up,
  output logic o_cal_gain,
  output logic o_commit,
  output logic [15:0] o_active_cfg
);
  import ccs_pkg::*;

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [7:0] stat;
    logic [15:0] in_val;
    logic [31:0] tick;
    logic unlocked;
    logic comp_en;
    logic cal_step;
    logic cal_up;
    logic cal_gain;
    logic commit;
    logic [15:0] active_cfg;
  } ccs_term_s;

  ccs_term_s q_ff, nxt_q;

  // limit comparison shared by both limit fields; a disabled limit reports zero
  function automatic logic [1:0] ccs_cmp(input logic en, input logic [15:0] v,
                                         input logic [15:0] lim);
    if (!en)
      ccs_cmp = LIM_OFF;
    else if (v < lim)
      ccs_cmp = LIM_BELOW;
    else if (v > lim)
      ccs_cmp = LIM_ABOVE;
    else
      ccs_cmp = LIM_EQUAL;
  endfunction

  // key register always open, otherwise a locked channel could never be unlocked
  function automatic logic ccs_may_write(input logic [5:0] a, input logic unl);
    if (a == REG_KEY)
      ccs_may_write = 1'b1;
    else if (a == REG_TYPE || a == REG_FW)
      ccs_may_write = 1'b0;
    else
      ccs_may_write = unl;
  endfunction

  function automatic logic [7:0] ccs_pd_status(input logic err, input logic [1:0] lim2_code,
    input logic [1:0] lim1_code, input logic over, input logic under);
    // bit 7 stays low so a process status never looks like a register answer
    ccs_pd_status = {1'b0, err, lim2_code, lim1_code, over, under};
  endfunction

  logic [5:0] addr;
  logic calib;
  logic [31:0] period;
  logic [31:0] tick_next;

  always_comb
  begin
    nxt_q = q_ff;
    addr = link.ctrl_byte[ADDR_W-1:0];
    calib = 1'b0;
    period = link.ctrl_byte[BIT_FAST] ? FAST_CYCLES : SLOW_CYCLES;
    tick_next = q_ff.tick + 32'h1;
    nxt_q.cal_step = 1'b0;
    nxt_q.commit = 1'b0;
    if (link.ctrl_byte[BIT_REG])
    begin
      // register traffic borrows the data bytes, so compensation and stepping pause
      nxt_q.comp_en = 1'b0;
      nxt_q.tick = '0;
      if (link.ctrl_byte[BIT_WR])
      begin
        // stored only, except a key write that locks or unlocks at once; behaviour changes at restart through active_cfg
        if (ccs_may_write(addr, q_ff.unlocked))
        begin
          nxt_q.regs[addr] = link.out_value;
        end
        if (addr == REG_KEY)
        begin
          nxt_q.unlocked = (link.out_value == UNLOCK_CODE);
          // commit only on the unlocked-to-locked step; a held write repeats harmlessly
          if (q_ff.unlocked && link.out_value != UNLOCK_CODE)
          begin
            nxt_q.commit = 1'b1;
          end
        end
        // acknowledge even when protection refused the value
        nxt_q.stat = {1'b1, 1'b0, addr};
        nxt_q.in_val = q_ff.in_val;
      end
      else
      begin
        nxt_q.stat = link.ctrl_byte;
        nxt_q.in_val = q_ff.regs[addr];
      end
    end
    else
    begin
      nxt_q.comp_en = link.ctrl_byte[BIT_COMP];
      // both directions at once is ambiguous, so no step is taken then
      calib = q_ff.unlocked && (link.ctrl_byte[BIT_GAIN] || link.ctrl_byte[BIT_OFFS]) &&
              (link.ctrl_byte[BIT_UP] ^ link.ctrl_byte[BIT_DOWN]);
      if (calib)
      begin
        if (tick_next >= period)
        begin
          nxt_q.tick = '0;
          nxt_q.cal_step = 1'b1;
        end
        else
        begin
          nxt_q.tick = tick_next;
        end
      end
      else
      begin
        // dropping the request restarts the period, so no early step follows
        nxt_q.tick = '0;
      end
      nxt_q.cal_up = link.ctrl_byte[BIT_UP];
      nxt_q.cal_gain = link.ctrl_byte[BIT_GAIN];
      nxt_q.stat = ccs_pd_status(i_error, ccs_cmp(i_limit2_en, i_sample, i_limit2),
                                 ccs_cmp(i_limit1_en, i_sample, i_limit1), i_overrange,
                                 i_underrange);
      nxt_q.in_val = i_sample;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      q_ff <= '0;
      q_ff.regs[REG_TYPE] <= TYPE_ID_DEF;
      q_ff.regs[REG_FW] <= FW_VER_DEF;
      q_ff.regs[REG_KEY] <= KEY_RESET;
      q_ff.active_cfg <= q_ff.regs[REG_FEATURE];
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign link.stat_byte = q_ff.stat;
  assign link.fill_in = FILL_BYTE;
  assign link.in_value = q_ff.in_val;
  assign o_comp_en = q_ff.comp_en;
  assign o_cal_step = q_ff.cal_step;
  assign o_cal_up = q_ff.cal_up;
  assign o_cal_gain = q_ff.cal_gain;
  assign o_commit = q_ff.commit;
  assign o_active_cfg = q_ff.active_cfg;
endmodule
`default_nettype wire

// ===== ccs_pkg.sv
// ccs_pkg: constants shared by both ends of the channel control/status byte link.
// assumes one clock (i_ref_clk, 200 MHz) and synchronous active-high reset on both ends.
// Behaviour
// - control bit 7 selects process data or register
// - control/status byte first, value in next two
// - word-aligned variant inserts filler byte after control
// - bit 6 chooses register read or write
// - bits 5..0 address one of 64 registers
// - write complete only after status acknowledge
// - read echoes control, returns register content
// - write acknowledge: address, bit7 set, bit6 clear
// - read ignores output value bytes
// - controller disregards input bytes after write
// - process mode bit 6 enables compensation
// - bit 4 gain, bit 3 offset calibration
// - bit 2 slow/fast cycle, bits 1/0 up/down
// - calibrate only when unlocked; commit on relock
// - status bit6 error, bit1 over, bit0 under
// - status 5:4 second limit comparison code
// - status 3:2 first limit comparison code
// - only key register writable while locked
// - unlock value lifts protection, other restores
// - written values take effect after restart
// - register 8 returns terminal type
// - register 9 returns firmware as two ASCII
`default_nettype none
package ccs_pkg;
  localparam int BIT_REG = 7;
  localparam int BIT_WR = 6;
  localparam int BIT_COMP = 6;
  localparam int BIT_GAIN = 4;
  localparam int BIT_OFFS = 3;
  localparam int BIT_FAST = 2;
  localparam int BIT_UP = 1;
  localparam int BIT_DOWN = 0;
  localparam int BIT_ERR = 6;
  localparam int BIT_OVER = 1;
  localparam int BIT_UNDER = 0;
  localparam int ADDR_W = 6;
  localparam int NREG = 64;
  localparam logic [5:0] REG_TYPE = 6'h08;
  localparam logic [5:0] REG_FW = 6'h09;
  localparam logic [5:0] REG_KEY = 6'h1F;
  localparam logic [5:0] REG_FEATURE = 6'h20;
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] KEY_RESET = 16'h0000;
  // arbitrary neutral identity values
  localparam logic [15:0] TYPE_ID_DEF = 16'h0101;
  localparam logic [15:0] FW_VER_DEF = 16'h3130;
  localparam int CLK_MHZ = 200;
  localparam int SLOW_MS = 1000;
  localparam int FAST_MS = 50;
  localparam int SLOW_CYC = SLOW_MS * 1000 * CLK_MHZ;
  localparam int FAST_CYC = FAST_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] LIM_OFF = 2'h0;
  localparam logic [1:0] LIM_BELOW = 2'h1;
  localparam logic [1:0] LIM_ABOVE = 2'h2;
  localparam logic [1:0] LIM_EQUAL = 2'h3;
  localparam logic [7:0] FILL_BYTE = 8'h00;
endpackage
`default_nettype wire

// ===== ccs_link_if.sv
// ccs_link_if: process-image bytes between controller and terminal channel.
// assumes both ends share i_ref_clk; controller drives outputs, terminal inputs.
`default_nettype none
interface ccs_link_if;
  logic [7:0] ctrl_byte;
  logic [7:0] fill_out;
  logic [15:0] out_value;
  logic [7:0] stat_byte;
  logic [7:0] fill_in;
  logic [15:0] in_value;
  modport terminal (input ctrl_byte, fill_out, out_value, output stat_byte, fill_in, in_value);
  modport controller (output ctrl_byte, fill_out, out_value, input stat_byte, fill_in, in_value);
endinterface
`default_nettype wire

// ===== ccs_controller.sv
// ccs_controller: coupler end; runs one register access at a time.
// assumes the terminal answers on the link from the cycle after a control byte change.
`default_nettype none
module ccs_controller (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  ccs_link_if.controller link,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [5:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_pd_ctrl,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic [7:0] o_pd_status,
  output logic [15:0] o_pd_value
);
  import ccs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } ccs_ctl_e;

  typedef struct packed {
    ccs_ctl_e st;
    logic [7:0] ctrl;
    logic [15:0] outv;
    logic done;
    logic [15:0] rdata;
    logic [7:0] pd_stat;
    logic [15:0] pd_val;
  } ccs_ctl_s;

  ccs_ctl_s q_ff, nxt_q;
  logic [7:0] expect_stat;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    expect_stat = q_ff.ctrl[BIT_WR] ? {1'b1, 1'b0, q_ff.ctrl[5:0]} : q_ff.ctrl;
    case (q_ff.st)
      ST_IDLE:
      begin
        nxt_q.ctrl = {1'b0, i_pd_ctrl[6:0]};
        if (!link.stat_byte[BIT_REG])
        begin
          nxt_q.pd_stat = link.stat_byte;
          nxt_q.pd_val = link.in_value;
        end
        if (i_req)
        begin
          nxt_q.ctrl = {1'b1, i_write, i_addr};
          nxt_q.outv = i_write ? i_wdata : 16'h0000;
          nxt_q.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (link.stat_byte == expect_stat)
        begin
          if (!q_ff.ctrl[BIT_WR])
            nxt_q.rdata = link.in_value;
          nxt_q.done = 1'b1;
          nxt_q.st = ST_IDLE;
          nxt_q.ctrl = {1'b0, i_pd_ctrl[6:0]};
        end
      end
      default:
        nxt_q.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  assign link.ctrl_byte = q_ff.ctrl;
  assign link.fill_out = FILL_BYTE;
  assign link.out_value = q_ff.outv;
  assign o_busy = (q_ff.st == ST_WAIT);
  assign o_done = q_ff.done;
  assign o_rdata = q_ff.rdata;
  assign o_pd_status = q_ff.pd_stat;
  assign o_pd_value = q_ff.pd_val;
endmodule
`default_nettype wire

// ===== ccs_checker.sv
// ccs_checker: protocol assertions on the link between controller and terminal.
// assumes plain link signals with the shared clock and synchronous reset.
`default_nettype none
module ccs_checker
  import ccs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [7:0] ctrl_byte,
  input wire logic [15:0] out_value,
  input wire logic [7:0] stat_byte,
  input wire logic [7:0] fill_in,
  input wire logic [15:0] in_value
);
  // shadow of the key register; it is writable in every state
  logic [15:0] key_ff;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      key_ff <= KEY_RESET;
    else if (ctrl_byte == {2'b11, REG_KEY})
      key_ff <= out_value;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_read_echo: assert property (ctrl_byte[7:6] == 2'b10 |=> stat_byte == $past(ctrl_byte))
    else $error("read status not echoed");
  a_write_ack: assert property (ctrl_byte[7:6] == 2'b11 |=> stat_byte[7:6] == 2'b10
    && stat_byte[5:0] == $past(ctrl_byte[5:0])) else $error("bad write ack");
  a_pd_top_low: assert property (!ctrl_byte[7] |=> !stat_byte[7])
    else $error("status bit 7 set in process mode");
  a_filler_zero: assert property (fill_in == FILL_BYTE)
    else $error("filler byte not zero");
  a_type_read: assert property (ctrl_byte == {2'b10, REG_TYPE} |=> in_value == TYPE_ID_DEF)
    else $error("bad type value");
  a_fw_read: assert property (ctrl_byte == {2'b10, REG_FW} |=> in_value == FW_VER_DEF)
    else $error("bad firmware value");
  a_key_read: assert property (ctrl_byte == {2'b10, REG_KEY} |=> in_value == $past(key_ff))
    else $error("key read mismatch");
  a_read_steady: assert property (ctrl_byte == {2'b10, REG_KEY} && $stable(ctrl_byte)
    |=> $stable(in_value)) else $error("read disturbed value");
endmodule
`default_nettype wire

// ===== test_channel_control_status_byte_protocol.sv
// test_channel_control_status_byte_protocol: controller and terminal joined by the link.
// assumes the package, interface, both ends and ccs_checker are compiled first.
`default_nettype none
module test_channel_control_status_byte_protocol;
  timeunit 1ns;
  timeprecision 100ps;
  import ccs_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_req = 1'b0;
  logic i_write = 1'b0;
  logic [5:0] i_addr = 6'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [7:0] i_pd_ctrl = 8'h00;
  logic [15:0] smp = 16'h0000;
  logic [15:0] lim1 = 16'h0000;
  logic [15:0] lim2 = 16'h0000;
  logic [5:0] flg = 6'h00;
  logic o_done, o_comp_en, o_cal_step, o_cal_up, o_cal_gain, o_commit;
  logic o_busy;
  logic [15:0] o_active_cfg;
  logic [15:0] o_rdata, o_pd_value, d;
  logic [7:0] o_pd_status;
  logic [16:0] exp_q[$];
  int err_count = 0;
  int samples_checked = 0;
  int done_cnt = 0;
  int cal_cnt = 0;
  int com_cnt = 0;
  integer seed = 49789;
  always #2.5 i_ref_clk = ~i_ref_clk;
  ccs_link_if link();
  // short step counts keep calibration visible within a few dozen cycles
  ccs_terminal #(.SLOW_CYCLES(8), .FAST_CYCLES(4)) ccs_terminal_i (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .link(link), .i_sample(smp), .i_error(flg[0]), .i_overrange(flg[1]),
    .i_underrange(flg[2]), .i_limit1(lim1), .i_limit2(lim2), .i_limit1_en(flg[3]),
    .i_limit2_en(flg[4]), .o_comp_en(o_comp_en), .o_cal_step(o_cal_step), .o_cal_up(o_cal_up),
    .o_cal_gain(o_cal_gain), .o_commit(o_commit), .o_active_cfg(o_active_cfg));
  ccs_controller ccs_controller_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .link(link),
    .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .i_pd_ctrl(i_pd_ctrl),
    .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .o_pd_status(o_pd_status),
    .o_pd_value(o_pd_value));
  ccs_checker ccs_checker_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .ctrl_byte(link.ctrl_byte), .out_value(link.out_value), .stat_byte(link.stat_byte),
    .fill_in(link.fill_in), .in_value(link.in_value));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one access; i_req pulses for one cycle, then the task waits until the done pulse has been seen
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] v,
    input logic [16:0] e);
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_write <= w;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    @(negedge i_ref_clk);
    chk("busy", {15'h0, o_busy}, 16'h1);
    wait (exp_q.size() == 0);
  endtask
  function automatic logic [1:0] lc(input logic en, input logic [15:0] s, input logic [15:0] l);
    return !en ? LIM_OFF : s < l ? LIM_BELOW : s > l ? LIM_ABOVE : LIM_EQUAL;
  endfunction
  // sampled away from the launching edge so registered outputs have settled
  always @(negedge i_ref_clk)
  begin
    if (o_cal_step === 1'b1)
      cal_cnt++;
    if (o_commit === 1'b1)
      com_cnt++;
    if (o_done === 1'b1 && exp_q.size() > 0)
    begin
      if (exp_q[0][16])
        chk("rdata", o_rdata, exp_q[0][15:0]);
      void'(exp_q.pop_front());
      done_cnt++;
    end
    else if (o_done === 1'b1)
      chk("spurious done", 16'h1, 16'h0);
  end
  initial
  begin
    #10us;
    err_count++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    d = 16'($random(seed));
    acc(1'b0, REG_TYPE, d, {1'b1, TYPE_ID_DEF});
    acc(1'b0, REG_FW, d, {1'b1, FW_VER_DEF});
    acc(1'b1, REG_TYPE, d, 17'h0);
    acc(1'b0, REG_TYPE, 16'h0, {1'b1, TYPE_ID_DEF});
    acc(1'b1, 6'h03, d, 17'h0);
    acc(1'b0, 6'h03, 16'h0, 17'h10000);
    acc(1'b1, REG_KEY, UNLOCK_CODE, 17'h0);
    acc(1'b0, REG_KEY, d, {1'b1, UNLOCK_CODE});
    acc(1'b1, 6'h03, d, 17'h0);
    acc(1'b0, 6'h03, 16'h0, {1'b1, d});
    acc(1'b1, REG_FEATURE, d | 16'h8000, 17'h0);
    acc(1'b0, REG_FEATURE, 16'h0, {1'b1, d | 16'h8000});
    chk("cfg at write", o_active_cfg, 16'h0000);
    $display("register test done");
    i_pd_ctrl <= 8'h56;
    repeat (30) @(posedge i_ref_clk);
    chk("cal steps", 16'(cal_cnt != 0), 16'h1);
    chk("cal mode", {13'h0, o_comp_en, o_cal_gain, o_cal_up}, 16'h7);
    acc(1'b1, REG_KEY, 16'h0, 17'h0);
    repeat (2) @(posedge i_ref_clk);
    cal_cnt = 0;
    repeat (30) @(posedge i_ref_clk);
    chk("commit", 16'(com_cnt), 16'h1);
    chk("locked steps", 16'(cal_cnt), 16'h0);
    $display("calibration test done");
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_reset <= 1'b0;
    @(negedge i_ref_clk);
    chk("cfg at restart", o_active_cfg, d | 16'h8000);
    $display("restart test done");
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_ref_clk);
      smp <= 16'($random(seed) & 3);
      lim1 <= 16'($random(seed) & 3);
      lim2 <= 16'($random(seed) & 3);
      flg <= 6'($random(seed));
      i_pd_ctrl <= 8'h00;
      @(posedge i_ref_clk);
      i_pd_ctrl <= {1'b0, flg[5], 6'h00};
      repeat (6) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk("status", {8'h0, o_pd_status}, {9'h0, flg[0], lc(flg[4], smp, lim2),
        lc(flg[3], smp, lim1), flg[1], flg[2]});
      chk("value", o_pd_value, smp);
      chk("comp", {15'h0, o_comp_en}, {15'h0, flg[5]});
    end
    $display("process data test done");
    stop_test();
  end
endmodule
`default_nettype wire
